// ==== rtl/assp_defs.vh ====
// Purpose: constants for the angle short-stroke post-processing stage
// Assumes: 12-bit angle, 4096 counts per turn
// Notes: register index x sits at byte address 4*x
`ifndef ASSP_DEFS_VH
`define ASSP_DEFS_VH
`define ASSP_IDX_PRE 8'h3A
`define ASSP_IDX_GAIN 8'h3B
`define ASSP_IDX_LIM 8'h3C
`define ASSP_IDX_POST 8'h3D
`define ASSP_IDX_STS 8'h40
`define ASSP_IDX_MASK 8'h41
`define ASSP_IDX_STATE 8'h42
`define ASSP_PRE_LSB 12
`define ASSP_SS_BIT 25
`define ASSP_GAIN_W 13
`define ASSP_CE_BIT 25
`define ASSP_WRAP_BIT 24
`define ASSP_MAX_LSB 12
`define ASSP_PO_BIT 24
`define ASSP_POST_LSB 12
`define ASSP_HI_LSB 6
`define ASSP_CLAMP_W 6
`define ASSP_CFG_RST 26'h0000000
`define ASSP_EV_RANGE 0
`define ASSP_EV_SAMPLE 1
`define ASSP_EV_W 2
`define ASSP_GAIN_ONE 14'h0100
`define ASSP_RESP_OKAY 2'h0
`define ASSP_RESP_SLVERR 2'h2
`endif

// ==== rtl/assp_core.v ====
// Purpose: shapes each averaged angle sample for the output stage
// Assumes: 10 MHz clock, one sample per angle_valid pulse
// Notes: result appears one cycle after the sample is taken
`timescale 1ns/100ps
`include "assp_defs.vh"
module assp_core #(
	parameter AW = 12
) (
	input wire clock, // system clock
	input wire rst, // async reset, high
	input wire [11:0] angle_in, // averaged angle sample
	input wire angle_valid, // sample strobe
	output reg [11:0] angle_out_q, // processed angle
	output reg out_valid_q, // result strobe
	output reg out_tristate_q, // diagnostic tristate request
	output reg irq_q, // interrupt level
	input wire [AW-1:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // byte strobes
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [AW-1:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready // read data ready
);

////////////////////////////////////////////////////////////////////////////////
// Register select, shared by read and write paths
function [2:0] reg_sel;
	input [AW-1:0] addr;
	begin
		case (addr[AW-1:2])
			{2'h0, `ASSP_IDX_PRE}: reg_sel = 3'h1;
			{2'h0, `ASSP_IDX_GAIN}: reg_sel = 3'h2;
			{2'h0, `ASSP_IDX_LIM}: reg_sel = 3'h3;
			{2'h0, `ASSP_IDX_POST}: reg_sel = 3'h4;
			{2'h0, `ASSP_IDX_STS}: reg_sel = 3'h5;
			{2'h0, `ASSP_IDX_MASK}: reg_sel = 3'h6;
			{2'h0, `ASSP_IDX_STATE}: reg_sel = 3'h7;
			default: reg_sel = 3'h0;
		endcase
	end
endfunction

function [31:0] merge;
	input [31:0] old;
	input [31:0] data;
	input [3:0] strb;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1)
			if (strb[i])
				merge[i*8 +: 8] = data[i*8 +: 8];
	end
endfunction

reg [25:0] pre_q;
reg [25:0] gain_q;
reg [25:0] lim_q;
reg [25:0] post_q;
reg [`ASSP_EV_W-1:0] sts_q;
reg [`ASSP_EV_W-1:0] mask_q;
reg [AW-1:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg aw_have_q;
reg w_have_q;
wire do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
wire [2:0] wsel = reg_sel(awaddr_q);
wire [2:0] rsel = reg_sel(s_axi_araddr);
wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
// Reserved bits of offset and gain read back as zero
wire [31:0] pre_wr = merge({6'h00, pre_q}, wdata_q, wstrb_q) & 32'h00FFF000;
wire [31:0] gain_wr = merge({6'h00, gain_q}, wdata_q, wstrb_q) & 32'h02001FFF;
wire [31:0] lim_wr = merge({6'h00, lim_q}, wdata_q, wstrb_q);
wire [31:0] post_wr = merge({6'h00, post_q}, wdata_q, wstrb_q);

////////////////////////////////////////////////////////////////////////////////
// Configuration fields
wire ss_en = gain_q[`ASSP_SS_BIT];
wire [11:0] pre_off = pre_q[`ASSP_PRE_LSB +: 12];
wire [`ASSP_GAIN_W-1:0] gain_fld = gain_q[`ASSP_GAIN_W-1:0];
wire clamp_select = lim_q[`ASSP_CE_BIT];
wire limit_wrap_select = lim_q[`ASSP_WRAP_BIT];
wire [11:0] max_in = lim_q[`ASSP_MAX_LSB +: 12];
wire [11:0] min_in = lim_q[11:0];
wire polarity = post_q[`ASSP_PO_BIT];
wire [11:0] zero_shift_after_scale = post_q[`ASSP_POST_LSB +: 12];
wire [11:0] ceil_ang = {post_q[`ASSP_HI_LSB +: `ASSP_CLAMP_W], 6'h00};
wire [11:0] floor_ang = {post_q[`ASSP_CLAMP_W-1:0], 6'h00};

////////////////////////////////////////////////////////////////////////////////
// Angle datapath
reg [11:0] a_pre;
reg range_bad;
reg [13:0] mult;
reg [25:0] prod;
reg [17:0] scaled;
reg [18:0] shifted;
reg [12:0] span;
reg [18:0] rem;
reg [11:0] wrapped;
reg [11:0] shaped;
reg [11:0] final_ang;
always @*
begin
	// pre-gain offset
	// Subtracted in every mode, wraps within one turn
	a_pre = angle_in - pre_off;
	// bound check
	// Only meaningful while short stroke is on
	range_bad = ss_en & ((a_pre < min_in) | (a_pre > max_in));
	// gain as 1 + 5.8 field
	// Top gain near 33x stretches 11.25 degrees past a turn
	mult = `ASSP_GAIN_ONE + {1'b0, gain_fld};
	prod = a_pre * mult;
	scaled = ss_en ? prod[25:8] : {6'h00, a_pre};
	shifted = {1'b0, scaled} + {7'h00, zero_shift_after_scale};
	span = {1'b0, ceil_ang} - {1'b0, floor_ang} + 13'h0001;
	rem = 19'h00000;
	wrapped = shifted[11:0];
	case ({clamp_select, limit_wrap_select})
		2'b00:
		begin
			shaped = wrapped;
		end
		2'b01:
		begin
			// roll over between floor and ceiling
			// Inverted limits collapse to the floor
			if (ceil_ang > floor_ang)
			begin
				rem = shifted % {6'h00, span};
				shaped = floor_ang + rem[11:0];
			end
			else
				shaped = floor_ang;
		end
		2'b10:
		begin
			// clamp the unwrapped value, no roll-over
			if (shifted > {7'h00, ceil_ang})
				shaped = ceil_ang;
			else if (shifted < {7'h00, floor_ang})
				shaped = floor_ang;
			else
				shaped = shifted[11:0];
		end
		default:
		begin
			if (wrapped > ceil_ang)
				shaped = ceil_ang;
			else if (wrapped < floor_ang)
				shaped = floor_ang;
			else
				shaped = wrapped;
		end
	endcase
	final_ang = polarity ? (12'h000 - shaped) : shaped;
end

////////////////////////////////////////////////////////////////////////////////
// Output stage
// every sample runs the chain, gain only while short stroke is on
always @(posedge clock or posedge rst)
begin
	if (rst)
	begin
		angle_out_q <= 12'h000;
		out_valid_q <= 1'b0;
		out_tristate_q <= 1'b0;
	end
	else
	begin
		out_valid_q <= angle_valid;
		if (angle_valid)
		begin
			angle_out_q <= final_ang;
			// diagnostic wins over clamps
			// Held until the next sample decides again
			out_tristate_q <= range_bad;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Status, mask and interrupt
wire [`ASSP_EV_W-1:0] ev = {angle_valid, angle_valid & range_bad};
wire sts_wr = do_wr & (wsel == 3'h5) & wstrb_q[0];
wire [`ASSP_EV_W-1:0] sts_clr = sts_wr ? wdata_q[`ASSP_EV_W-1:0] : {`ASSP_EV_W{1'b0}};
// New events beat a same-cycle clear
wire [`ASSP_EV_W-1:0] sts_d = (sts_q & ~sts_clr) | ev;
always @(posedge clock or posedge rst)
begin
	if (rst)
	begin
		sts_q <= {`ASSP_EV_W{1'b0}};
		irq_q <= 1'b0;
	end
	else
	begin
		sts_q <= sts_d;
		irq_q <= |(sts_q & mask_q);
	end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel
always @(posedge clock or posedge rst)
begin
	if (rst)
	begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `ASSP_RESP_OKAY;
		aw_have_q <= 1'b0;
		w_have_q <= 1'b0;
		awaddr_q <= {AW{1'b0}};
		wdata_q <= 32'h00000000;
		wstrb_q <= 4'h0;
		pre_q <= `ASSP_CFG_RST;
		gain_q <= `ASSP_CFG_RST;
		lim_q <= `ASSP_CFG_RST;
		post_q <= `ASSP_CFG_RST;
		mask_q <= {`ASSP_EV_W{1'b0}};
	end
	else
	begin
		if (s_axi_awvalid & s_axi_awready)
		begin
			awaddr_q <= s_axi_awaddr;
			aw_have_q <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid & s_axi_wready)
		begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
			w_have_q <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (do_wr)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wsel == 3'h0) ? `ASSP_RESP_SLVERR : `ASSP_RESP_OKAY;
			case (wsel)
				3'h1: pre_q <= pre_wr[25:0];
				3'h2: gain_q <= gain_wr[25:0];
				3'h3: lim_q <= lim_wr[25:0];
				3'h4: post_q <= post_wr[25:0];
				3'h6: mask_q <= (wdata_q[`ASSP_EV_W-1:0] & wmask[`ASSP_EV_W-1:0])
					| (mask_q & ~wmask[`ASSP_EV_W-1:0]);
				default: pre_q <= pre_q;
			endcase
		end
		if (s_axi_bvalid & s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel
reg [31:0] rd_mux;
always @*
begin
	case (rsel)
		3'h1: rd_mux = {6'h00, pre_q};
		3'h2: rd_mux = {6'h00, gain_q};
		3'h3: rd_mux = {6'h00, lim_q};
		3'h4: rd_mux = {6'h00, post_q};
		3'h5: rd_mux = {30'h00000000, sts_q};
		3'h6: rd_mux = {30'h00000000, mask_q};
		3'h7: rd_mux = {19'h00000, out_tristate_q, angle_out_q};
		default: rd_mux = 32'h00000000;
	endcase
end

always @(posedge clock or posedge rst)
begin
	if (rst)
	begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `ASSP_RESP_OKAY;
	end
	else if (s_axi_arvalid & s_axi_arready)
	begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b1;
		s_axi_rdata <= rd_mux;
		s_axi_rresp <= (rsel == 3'h0) ? `ASSP_RESP_SLVERR : `ASSP_RESP_OKAY;
	end
	else if (s_axi_rvalid & s_axi_rready)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_arready <= 1'b1;
	end
end

endmodule // assp_core

// ==== verif/assp_core_properties.sv ====
// Purpose: port-level timing checks for the angle post-processing stage
// Assumes: one clock, rst asynchronous and active high
// Notes: angle values are judged by the bench model, not here
`timescale 1ns/100ps
module assp_core_props (
	input wire logic clock, // clock
	input wire logic rst, // reset
	input wire logic angle_valid, // sample in
	input wire logic out_valid_q, // result strobe
	input wire logic [11:0] angle_out_q, // angle out
	input wire logic out_tristate_q, // diag out
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic [31:0] s_axi_rdata // r data
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rd_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	sample_strobe_a: assert property (angle_valid |=> out_valid_q)
		else $error("result strobe missing");
	idle_strobe_a: assert property (!angle_valid |=> !out_valid_q)
		else $error("stray result strobe");
	output_hold_a: assert property (!angle_valid |=>
		$stable(angle_out_q) && $stable(out_tristate_q))
		else $error("output moved without a sample");
	diag_at_sample_a: assert property ($rose(out_tristate_q) |-> out_valid_q)
		else $error("diagnostic rose outside a sample");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	read_answer_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	rdata_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while answer pending");
endmodule // assp_core_props
bind assp_core assp_core_props assp_core_props_i (.clock, .rst, .angle_valid, .out_valid_q,
	.angle_out_q, .out_tristate_q, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ==== verif/tb_assp_core.sv ====
// Purpose: self-checking bench for the angle post-processing stage
// Assumes: 10 MHz clock, registers over AXI4-Lite
// Notes: expected angles come from the behavioural model below
`timescale 1ns/100ps
`include "assp_defs.vh"
module tb_assp_core;
	logic clock, rst, angle_valid, out_valid_q, out_tristate_q, irq_q;
	logic [11:0] angle_in, angle_out_q, s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int err_total, num_checks, i, pre, gn, mn, mx, po, flo, cei, ss, c, w, pol;
	assp_core assp_core_i (.clock, .rst, .angle_in, .angle_valid, .angle_out_q, .out_valid_q,
		.out_tristate_q, .irq_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Bready held up front; the response always follows both takes
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		int n;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clock);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50) err_total++;
	endtask
	task automatic rd(input logic [11:0] a);
		int n;
		@(posedge clock);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clock);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50) err_total++;
	endtask
	task automatic wcfg;
		wr(12'h0E8, pre << 12);
		wr(12'h0EC, (ss << 25) | gn);
		wr(12'h0F0, (c << 25) | (w << 24) | (mx << 12) | mn);
		wr(12'h0F4, (pol << 24) | (po << 12) | (cei << 6) | flo);
	endtask
	// Result packed as diagnostic bit above the 12-bit angle
	function automatic int model(input int x);
		int a, s, fl, ce, bad;
		a = (x + 4096 - pre) % 4096;
		bad = ss && (a < mn || a > mx);
		if (ss) a = a * (256 + gn) / 256;
		s = a + po;
		fl = flo * 64;
		ce = cei * 64;
		if (!c && w) s = (ce <= fl) ? fl : fl + s % (ce - fl + 1);
		// Clamp-only mode limits the unwrapped sum
		if (c == w) s = s % 4096;
		if (c) s = (s < fl) ? fl : (s > ce) ? ce : s;
		if (pol) s = (4096 - s) % 4096;
		return bad * 4096 + s;
	endfunction
	task automatic chk(input int x);
		int e;
		e = model(x);
		@(posedge clock);
		angle_in <= x[11:0];
		angle_valid <= 1'b1;
		@(posedge clock);
		angle_valid <= 1'b0;
		#1;
		cmp({out_tristate_q, angle_out_q}, e);
	endtask
	// Irq lags status by a cycle, so allow two edges
	task automatic irqis(input logic v);
		repeat (2) @(posedge clock);
		#1;
		cmp(irq_q, v);
	endtask
	task summarize;
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial
	begin
		#500000;
		err_total++;
		summarize();
	end
	initial
	begin
		rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, angle_in, angle_valid} = 37'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		for (i = 0; i < 6; i++)
		begin
			rd(i < 4 ? 12'h0E8 + 4 * i : 12'h0F0 + 4 * i);
			cmp(d, 32'h0);
		end
		chk(12'h123);
		pre = 12'h100;
		wcfg();
		chk(12'h050);
		pol = 1;
		wcfg();
		chk(12'h000);
		chk(12'h400);
		{pol, pre, ss, gn, mx} = {32'h0, 32'h0, 32'h1, 32'h380, 32'hFFF};
		wcfg();
		chk(12'hFFF);
		chk(12'h000);
		chk(12'h800);
		{gn, po, flo, cei} = {32'h300, 32'h40, 32'h1, 32'h30};
		for (i = 0; i < 4; i++)
		begin
			c = i / 2;
			w = i % 2;
			wcfg();
			chk(12'h300);
			chk(12'h3F0);
			chk(12'h005);
		end
		ss = 0;
		wcfg();
		chk(12'h300);
		// Low ceiling so the out-of-range sample would also be clamped
		{ss, gn, mn, mx, c, w, po, flo, cei} = {32'h1, 32'h0, 32'h100, 32'h200, 32'h1,
			32'h0, 32'h0, 32'h0, 32'h4};
		wcfg();
		chk(12'h0FF);
		chk(12'h201);
		chk(12'h200);
		irqis(1'b0);
		wr(12'h104, 32'h1);
		irqis(1'b1);
		wr(12'h100, 32'h1);
		cmp(r, `ASSP_RESP_OKAY);
		irqis(1'b0);
		chk(12'h201);
		irqis(1'b1);
		rd(12'h100);
		cmp(d, 32'h3);
		rd(12'h108);
		cmp(d, model(12'h201));
		rd(12'h010);
		cmp(d, 32'h0);
		cmp(r, `ASSP_RESP_SLVERR);
		wr(12'h010, 32'h1);
		cmp(r, `ASSP_RESP_SLVERR);
		// Only the low byte may change
		s_axi_wstrb <= 4'h1;
		wr(12'h0F0, 32'hFFFFFF55);
		s_axi_wstrb <= 4'hF;
		rd(12'h0F0);
		cmp(d, 32'h02200155);
		ss = 0;
		wcfg();
		chk(12'h201);
		summarize();
	end
endmodule // tb_assp_core
